// ==== core/quad_flash_desc_ctrl_taps.v ====
// apb register slice: descriptor control, current pointer and delay taps
//
// Overview of operation
// RULE1 - control bits start, poll enable, dma enable
// RULE2 - poll enable turns descriptor polling on
// RULE3 - upper bits read zero, bits reset zero
// RULE4 - read-only pointer of current descriptor
// RULE5 - ddr sample clock delay, n plus one
// RULE6 - sdr data delay, n plus one taps
// RULE7 - ddr data output delay, n plus one
// RULE8 - other tap fields, same n plus one
`timescale 1ns/1ps
`default_nettype none
`include "quad_flash_desc_ctrl_map.vh"

module quad_flash_desc_ctrl_taps #(
    parameter ADDR_WIDTH = 12,
    parameter POLL_CYCLES = `POLL_CYCLES
) (
    // clock and reset
    input wire SYS_CLK_IN,
    input wire SRST_IN,
    // apb slave
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [ADDR_WIDTH-1:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    input wire [3:0] PSTRB_IN,
    output reg [31:0] PRDATA_OUT,
    output reg PREADY_OUT,
    output reg PSLVERR_OUT,
    // descriptor fetch port
    input wire FETCH_ACK_IN,
    input wire DESC_OWNED_IN,
    input wire DESC_LAST_IN,
    input wire [31:0] NEXT_DESC_ADDR_IN,
    output wire FETCH_REQ_OUT,
    output reg [31:0] FETCH_ADDR_OUT,
    output wire PROCESSOR_BUSY_OUT,
    // control levels to the transfer engine
    output reg DMA_TRANSFER_ENABLE_OUT,
    output reg DESCRIPTOR_POLL_ENABLE_OUT,
    // tap counts to the delay lines
    output reg [6:0] DDR_SAMPLE_CLOCK_TAPS_OUT,
    output reg [4:0] SDR_DATA_TAPS_OUT,
    output reg [4:0] DDR_DATA_OUT_TAPS_OUT,
    output reg [6:0] SDR_SAMPLE_CLOCK_TAPS_OUT,
    output reg [4:0] DATA_OUTPUT_TAPS_OUT,
    output reg [4:0] CLOCK_OUTPUT_TAPS_OUT
);

    // helpers:
    // strobe merge is shared by the base and tap registers,
    // the tap conversions by all six delay outputs
    // merge write data into a register under byte strobes
    function [31:0] apply_strobe;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer i;
        begin
            apply_strobe = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    apply_strobe[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // wide field: value n gives n plus one taps
    function [6:0] wide_taps;
        input [5:0] field;
        begin
            wide_taps = {1'b0, field} + 7'h01;
        end
    endfunction

    // narrow field: value n gives n plus one taps
    function [4:0] narrow_taps;
        input [3:0] field;
        begin
            narrow_taps = {1'b0, field} + 5'h01;
        end
    endfunction

    // true when the address hits a mapped register
    function is_mapped;
        input [ADDR_WIDTH-1:0] addr;
        begin
            is_mapped = (addr == `DESC_CTRL_OFFSET) ||
                        (addr == `DESC_POINTER_OFFSET) ||
                        (addr == `DESC_BASE_OFFSET) ||
                        (addr == `TAP_CTRL_OFFSET);
        end
    endfunction

    // register image kept here; the pointer lives in the walker
    // so that software can only read it, never write it
    // base register holds the chain head, read and write,
    // copied into the pointer whenever the walker leaves idle
    // software visible state
    reg [`CTRL_WIDTH-1:0] desc_ctrl;   // start, poll, dma
    reg [31:0] desc_base;              // chain head address
    reg [31:0] tap_ctrl;               // packed tap fields

    // setup is the only cycle in which the answer is armed;
    // a write commits only with ready high, so a stalled or
    // repeated access phase never writes twice
    // bus phase decode
    wire setup_phase;                  // first cycle of a transfer
    wire write_commit;                 // write lands this edge
    reg [31:0] next_rdata;             // read mux result

    // control bits fan out to the walker with no register stage,
    // so a start write is acted on at the very next edge
    // walker wiring
    wire start_bit;                    // processor start request
    wire poll_bit;                     // polling allowed
    wire dma_bit;                      // dma allowed
    wire [31:0] cur_ptr;               // pointer from walker

    assign setup_phase = PSEL_IN && !PENABLE_IN;
    assign write_commit = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;

    assign start_bit = desc_ctrl[`CTRL_START_BIT];
    assign poll_bit = desc_ctrl[`CTRL_POLL_BIT];
    assign dma_bit = desc_ctrl[`CTRL_DMA_BIT];

    // the mux follows the address of the setup cycle;
    // the answer process latches it, so read data
    // leaves on a flop and is stable for the whole
    // access cycle
    // read mux, unimplemented bits return zero
    always @* begin
        next_rdata = 32'h0000_0000;
        case (PADDR_IN)
            `DESC_CTRL_OFFSET: begin
                next_rdata = {29'h0000_0000, desc_ctrl}; // RULE3
            end
            `DESC_POINTER_OFFSET: begin
                next_rdata = cur_ptr; // RULE4
            end
            `DESC_BASE_OFFSET: begin
                next_rdata = desc_base;
            end
            `TAP_CTRL_OFFSET: begin
                next_rdata = tap_ctrl & `TAP_CTRL_MASK;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // slave timing:
    // setup seen at an edge raises ready for the next cycle
    // a write lands at the edge where ready meets enable
    // ready, error and read data stand one cycle only
    // no wait state is ever inserted, so a master that
    // waits for ready finishes every access in two cycles
    // an unmapped address answers with an error and zero data
    // apb answer: one wait-free access phase after setup
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
        end else if (setup_phase) begin
            // ready and data prepared for the access phase
            PREADY_OUT <= 1'b1;
            PSLVERR_OUT <= !is_mapped(PADDR_IN);
            // writes answer with zero data
            if (PWRITE_IN) begin
                PRDATA_OUT <= 32'h0000_0000;
            end else begin
                PRDATA_OUT <= next_rdata;
            end
        end else begin
            // transfer closes, answer withdrawn
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
        end
    end

    // control write decode:
    // the three control bits sit in byte lane 0, so a write
    // without that lane leaves the word untouched;
    // a write to the pointer offset matches no decode and
    // is dropped without an error
    // control register, only three bits held
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            desc_ctrl <= `DESC_CTRL_RESET; // RULE3
        end else if (write_commit && PADDR_IN == `DESC_CTRL_OFFSET && PSTRB_IN[0]) begin
            desc_ctrl <= PWDATA_IN[`CTRL_WIDTH-1:0]; // RULE1
        end
    end

    // all four byte lanes honoured on the chain head
    // a change only matters the next time the walker starts
    // chain head address
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            desc_base <= `DESC_BASE_RESET;
        end else if (write_commit && PADDR_IN == `DESC_BASE_OFFSET) begin
            desc_base <= apply_strobe(desc_base, PWDATA_IN, PSTRB_IN);
        end
    end

    // masking on the way in keeps bits 31:30 and 15:14 at zero
    // in the register itself, so those bits can never reach
    // the delay outputs
    // tap control, unimplemented bits forced to zero
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            tap_ctrl <= `TAP_CTRL_RESET;
        end else if (write_commit && PADDR_IN == `TAP_CTRL_OFFSET) begin
            tap_ctrl <= apply_strobe(tap_ctrl, PWDATA_IN, PSTRB_IN) & `TAP_CTRL_MASK;
        end
    end

    // enables reach the transfer engine one cycle after the
    // write lands; the walker reads the register bits
    // directly, so it sees them a cycle earlier
    // control levels out to the transfer engine
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            DMA_TRANSFER_ENABLE_OUT <= 1'b0;
            DESCRIPTOR_POLL_ENABLE_OUT <= 1'b0;
        end else begin
            DMA_TRANSFER_ENABLE_OUT <= dma_bit; // RULE1
            DESCRIPTOR_POLL_ENABLE_OUT <= poll_bit; // RULE2
        end
    end

    // tap counts leave on flops so the delay lines never see
    // a decode glitch; a new setting takes effect one cycle
    // after the write lands
    // wide fields give 1 to 64 taps, narrow fields 1 to 16
    // the reset value of every count is one tap
    // tap counts, each field value plus one
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            DDR_SAMPLE_CLOCK_TAPS_OUT <= 7'h01;
            SDR_DATA_TAPS_OUT <= 5'h01;
            DDR_DATA_OUT_TAPS_OUT <= 5'h01;
            SDR_SAMPLE_CLOCK_TAPS_OUT <= 7'h01;
            DATA_OUTPUT_TAPS_OUT <= 5'h01;
            CLOCK_OUTPUT_TAPS_OUT <= 5'h01;
        end else begin
            DDR_SAMPLE_CLOCK_TAPS_OUT <=
                wide_taps(tap_ctrl[`TAP_DDR_CLK_IN_LSB +: `TAP_WIDE_BITS]); // RULE5
            SDR_DATA_TAPS_OUT <=
                narrow_taps(tap_ctrl[`TAP_SDR_DATA_LSB +: `TAP_NARROW_BITS]); // RULE6
            DDR_DATA_OUT_TAPS_OUT <=
                narrow_taps(tap_ctrl[`TAP_DDR_DATA_OUT_LSB +: `TAP_NARROW_BITS]); // RULE7
            SDR_SAMPLE_CLOCK_TAPS_OUT <=
                wide_taps(tap_ctrl[`TAP_SDR_CLK_IN_LSB +: `TAP_WIDE_BITS]); // RULE8
            DATA_OUTPUT_TAPS_OUT <=
                narrow_taps(tap_ctrl[`TAP_DATA_OUT_LSB +: `TAP_NARROW_BITS]); // RULE8
            CLOCK_OUTPUT_TAPS_OUT <=
                narrow_taps(tap_ctrl[`TAP_CLK_OUT_LSB +: `TAP_NARROW_BITS]); // RULE8
        end
    end

    // the walker moves its pointer one cycle before it raises
    // a request, so the registered address is settled by the
    // time the memory side samples the request
    // it trails the pointer by exactly one cycle
    // fetch address follows the walker pointer
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            FETCH_ADDR_OUT <= 32'h0000_0000;
        end else begin
            FETCH_ADDR_OUT <= cur_ptr;
        end
    end

    // walker handshake:
    // the request stays up until the edge where the answer is
    // seen; owned, last and link are taken at that edge only
    // a not-owned descriptor is fetched again after the poll
    // wait if polling is on, otherwise the walker parks
    // clearing start returns it to idle and keeps the pointer
    // descriptor walker
    descriptor_processor #(
        .POLL_CYCLES(POLL_CYCLES)
    ) descriptor_processor_inst (
        .clk(SYS_CLK_IN),
        .srst(SRST_IN),
        .start(start_bit),
        .poll_en(poll_bit),
        .dma_en(dma_bit),
        .base_addr(desc_base),
        .fetch_ack(FETCH_ACK_IN),
        .desc_owned(DESC_OWNED_IN),
        .desc_last(DESC_LAST_IN),
        .next_addr(NEXT_DESC_ADDR_IN),
        .fetch_req(FETCH_REQ_OUT),
        .cur_ptr(cur_ptr),
        .busy(PROCESSOR_BUSY_OUT)
    );

endmodule // quad_flash_desc_ctrl_taps
`default_nettype wire

// ==== core/quad_flash_desc_ctrl_map.vh ====
// register offsets, field positions, reset values and timing for the flash descriptor block
`ifndef QUAD_FLASH_DESC_CTRL_MAP_VH
`define QUAD_FLASH_DESC_CTRL_MAP_VH

// register byte offsets inside the block window
`define DESC_CTRL_OFFSET 12'h034
`define DESC_POINTER_OFFSET 12'h038
`define DESC_BASE_OFFSET 12'h040
`define TAP_CTRL_OFFSET 12'h050

// descriptor control bit positions
`define CTRL_DMA_BIT 0
`define CTRL_POLL_BIT 1
`define CTRL_START_BIT 2
`define CTRL_WIDTH 3

// tap control field positions (lsb of each field)
`define TAP_DDR_CLK_IN_LSB 24
`define TAP_SDR_DATA_LSB 20
`define TAP_DDR_DATA_OUT_LSB 16
`define TAP_SDR_CLK_IN_LSB 8
`define TAP_DATA_OUT_LSB 4
`define TAP_CLK_OUT_LSB 0
`define TAP_WIDE_BITS 6
`define TAP_NARROW_BITS 4

// implemented bits of tap control, 31:30 and 15:14 read as zero
`define TAP_CTRL_MASK 32'h3FFF_3FFF

// reset values
`define DESC_CTRL_RESET 3'h0
`define DESC_POINTER_RESET 32'h0000_0000
`define DESC_BASE_RESET 32'h0000_0000
`define TAP_CTRL_RESET 32'h0000_0000

// polling interval between descriptor re-fetches
`define CLK_PERIOD_NS 10
`define POLL_INTERVAL_NS 160
`define POLL_CYCLES (`POLL_INTERVAL_NS / `CLK_PERIOD_NS)

`endif

// ==== core/descriptor_processor.v ====
// descriptor walker: fetches descriptors and tracks the current pointer
`timescale 1ns/1ps
`default_nettype none
`include "quad_flash_desc_ctrl_map.vh"

module descriptor_processor #(
    parameter POLL_CYCLES = `POLL_CYCLES
) (
    input wire clk,
    input wire srst,
    input wire start,                  // processor run request
    input wire poll_en,                // re-fetch not-ready descriptors
    input wire dma_en,                 // allow descriptor fetches
    input wire [31:0] base_addr,       // first descriptor address
    input wire fetch_ack,              // fetch answered this cycle
    input wire desc_owned,             // fetched descriptor is ready
    input wire desc_last,              // fetched descriptor ends chain
    input wire [31:0] next_addr,       // link to following descriptor
    output reg fetch_req,              // fetch request, held until ack
    output reg [31:0] cur_ptr,         // current descriptor address
    output reg busy                    // walking a chain
);

    // walker states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_FETCH = 2'b01;
    localparam [1:0] ST_POLL_WAIT = 2'b10;
    localparam [1:0] ST_HALT = 2'b11;

    reg [1:0] state;                   // walker state
    reg [15:0] poll_cnt;               // cycles left before re-fetch

    // walker sequencing
    always @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            fetch_req <= 1'b0;
            cur_ptr <= `DESC_POINTER_RESET; // RULE4
            busy <= 1'b0;
            poll_cnt <= 16'h0000;
        end else if (!start) begin
            // cleared start disables the walker, pointer kept
            state <= ST_IDLE; // RULE1
            fetch_req <= 1'b0;
            busy <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // fresh start loads the chain head
                    cur_ptr <= base_addr; // RULE4
                    busy <= 1'b1;
                    state <= ST_FETCH;
                end
                ST_FETCH: begin
                    if (fetch_req && fetch_ack) begin
                        fetch_req <= 1'b0;
                        if (!desc_owned) begin
                            // not ready: poll again or stop
                            if (poll_en) begin
                                poll_cnt <= POLL_CYCLES[15:0] - 16'h0001; // RULE2
                                state <= ST_POLL_WAIT;
                            end else begin
                                state <= ST_HALT; // RULE2
                            end
                        end else if (desc_last) begin
                            state <= ST_HALT;
                        end else begin
                            cur_ptr <= next_addr; // RULE4
                        end
                    end else if (!fetch_req) begin
                        // fetches only run with dma enabled
                        fetch_req <= dma_en; // RULE1
                    end
                end
                ST_POLL_WAIT: begin
                    if (!poll_en) begin
                        state <= ST_HALT; // RULE2
                    end else if (poll_cnt == 16'h0000) begin
                        state <= ST_FETCH; // RULE2
                    end else begin
                        poll_cnt <= poll_cnt - 16'h0001;
                    end
                end
                ST_HALT: begin
                    // parked until software drops start
                    busy <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // descriptor_processor
`default_nettype wire

// ==== tb/quad_flash_desc_ctrl_taps_properties.sv ====
// checker for the descriptor control and tap register slice
`timescale 1ns/1ps
`default_nettype none
`include "quad_flash_desc_ctrl_map.vh"
module quad_flash_desc_ctrl_taps_properties #(
    parameter ADDR_WIDTH = 12
) (
    input wire logic SYS_CLK_IN,
    input wire logic SRST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [ADDR_WIDTH-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic DMA_TRANSFER_ENABLE_OUT,
    input wire logic DESCRIPTOR_POLL_ENABLE_OUT,
    input wire logic [6:0] DDR_SAMPLE_CLOCK_TAPS_OUT,
    input wire logic [4:0] SDR_DATA_TAPS_OUT,
    input wire logic [4:0] DDR_DATA_OUT_TAPS_OUT,
    input wire logic [6:0] SDR_SAMPLE_CLOCK_TAPS_OUT,
    input wire logic [4:0] DATA_OUTPUT_TAPS_OUT,
    input wire logic [4:0] CLOCK_OUTPUT_TAPS_OUT
);
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SRST_IN);
    // accesses completing at the ready edge
    wire done = PSEL_IN && PENABLE_IN && PREADY_OUT;
    wire wr_ctrl = done && PWRITE_IN && PSTRB_IN[0] && PADDR_IN == `DESC_CTRL_OFFSET;
    wire rd_ctrl = done && !PWRITE_IN && PADDR_IN == `DESC_CTRL_OFFSET;
    wire rd_tap = done && !PWRITE_IN && PADDR_IN == `TAP_CTRL_OFFSET;
    ready_pulse_a:
        assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
            else $error("ready is not one cycle after setup");
    dma_copy_a:
        assert property (wr_ctrl |-> ##2 DMA_TRANSFER_ENABLE_OUT == $past(PWDATA_IN[0], 2))
            else $error("dma level does not follow its bit");
    poll_copy_a:
        assert property (wr_ctrl |-> ##2 DESCRIPTOR_POLL_ENABLE_OUT == $past(PWDATA_IN[1], 2))
            else $error("poll level does not follow its bit");
    ctrl_read_a:
        assert property (rd_ctrl |-> PRDATA_OUT[31:3] == 29'h0
            && PRDATA_OUT[1:0] == {DESCRIPTOR_POLL_ENABLE_OUT, DMA_TRANSFER_ENABLE_OUT})
            else $error("control read back wrong");
    ddr_clk_tap_a:
        assert property (rd_tap |-> DDR_SAMPLE_CLOCK_TAPS_OUT == PRDATA_OUT[29:24] + 7'h1
            && PRDATA_OUT[31:30] == 2'h0) else $error("ddr sample clock taps wrong");
    sdr_data_tap_a:
        assert property (rd_tap |-> SDR_DATA_TAPS_OUT == PRDATA_OUT[23:20] + 5'h1)
            else $error("sdr data taps wrong");
    ddr_out_tap_a:
        assert property (rd_tap |-> DDR_DATA_OUT_TAPS_OUT == PRDATA_OUT[19:16] + 5'h1)
            else $error("ddr data out taps wrong");
    other_taps_a:
        assert property (rd_tap |-> SDR_SAMPLE_CLOCK_TAPS_OUT == PRDATA_OUT[13:8] + 7'h1
            && DATA_OUTPUT_TAPS_OUT == PRDATA_OUT[7:4] + 5'h1
            && CLOCK_OUTPUT_TAPS_OUT == PRDATA_OUT[3:0] + 5'h1 && PRDATA_OUT[15:14] == 2'h0)
            else $error("remaining taps wrong");
endmodule // quad_flash_desc_ctrl_taps_properties
bind quad_flash_desc_ctrl_taps quad_flash_desc_ctrl_taps_properties #(.ADDR_WIDTH(ADDR_WIDTH))
    quad_flash_desc_ctrl_taps_properties_inst (.SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .DMA_TRANSFER_ENABLE_OUT(DMA_TRANSFER_ENABLE_OUT),
    .DESCRIPTOR_POLL_ENABLE_OUT(DESCRIPTOR_POLL_ENABLE_OUT),
    .DDR_SAMPLE_CLOCK_TAPS_OUT(DDR_SAMPLE_CLOCK_TAPS_OUT), .SDR_DATA_TAPS_OUT(SDR_DATA_TAPS_OUT),
    .DDR_DATA_OUT_TAPS_OUT(DDR_DATA_OUT_TAPS_OUT), .DATA_OUTPUT_TAPS_OUT(DATA_OUTPUT_TAPS_OUT),
    .SDR_SAMPLE_CLOCK_TAPS_OUT(SDR_SAMPLE_CLOCK_TAPS_OUT),
    .CLOCK_OUTPUT_TAPS_OUT(CLOCK_OUTPUT_TAPS_OUT));
`default_nettype wire

// ==== tb/desc_fetch_model.sv ====
// descriptor memory model answering the walker's fetches
`timescale 1ns/1ps
`default_nettype none
module desc_fetch_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic [31:0] addr_in,
    input wire logic owned_cfg_in,
    input wire logic last_cfg_in,
    input wire logic [1:0] delay_in,
    output logic ack_out,
    output logic owned_out,
    output logic last_out,
    output logic [31:0] next_out
);
    logic [1:0] cnt; // cycles waited on the open fetch
    // answer after the delay; between answers the reply lines toggle
    always @(posedge clk_in) begin
        ack_out <= 1'h0;
        owned_out <= ~owned_out;
        last_out <= ~last_out;
        next_out <= ~next_out;
        if (rst_in) begin
            cnt <= 2'h0;
            owned_out <= 1'h0;
            last_out <= 1'h0;
            next_out <= 32'h0000_0000;
        end else if (!req_in || ack_out) begin
            cnt <= 2'h0;
        end else if (cnt == delay_in) begin
            ack_out <= 1'h1;
            owned_out <= owned_cfg_in;
            last_out <= last_cfg_in;
            next_out <= addr_in + 32'h0000_0010;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule // desc_fetch_model
`default_nettype wire

// ==== tb/quad_flash_desc_ctrl_taps_tb_top.sv ====
// testbench for the descriptor control and tap register slice
`timescale 1ns/1ps
`default_nettype none
`include "quad_flash_desc_ctrl_map.vh"
module quad_flash_desc_ctrl_taps_tb_top;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, ow = 1'h0, ls = 1'h0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, seed = 32'h0000_af0a, rd, tap, d, b, prdata, fa, nx;
    logic [3:0] pstrb = 4'h0, s;
    logic [1:0] dly = 2'h0;
    logic [2:0] ctl;
    logic pready, pslverr, req, ack, owned, last, busy, dma, poll;
    logic [6:0] t_ddr_clk, t_sdr_clk;
    logic [4:0] t_sdr_dat, t_ddr_out, t_dat_out, t_clk_out;
    int fails = 0, num_checks = 0, acks = 0, a0, dlt;
    quad_flash_desc_ctrl_taps #(.POLL_CYCLES(2)) quad_flash_desc_ctrl_taps_inst (
        .SYS_CLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FETCH_ACK_IN(ack), .DESC_OWNED_IN(owned),
        .DESC_LAST_IN(last), .NEXT_DESC_ADDR_IN(nx), .FETCH_REQ_OUT(req), .FETCH_ADDR_OUT(fa),
        .PROCESSOR_BUSY_OUT(busy), .DMA_TRANSFER_ENABLE_OUT(dma), .DESCRIPTOR_POLL_ENABLE_OUT(poll),
        .DDR_SAMPLE_CLOCK_TAPS_OUT(t_ddr_clk), .SDR_DATA_TAPS_OUT(t_sdr_dat),
        .DDR_DATA_OUT_TAPS_OUT(t_ddr_out), .SDR_SAMPLE_CLOCK_TAPS_OUT(t_sdr_clk),
        .DATA_OUTPUT_TAPS_OUT(t_dat_out), .CLOCK_OUTPUT_TAPS_OUT(t_clk_out));
    desc_fetch_model desc_fetch_model_inst (.clk_in(clk), .rst_in(srst), .req_in(req),
        .addr_in(fa), .owned_cfg_in(ow), .last_cfg_in(ls), .delay_in(dly), .ack_out(ack),
        .owned_out(owned), .last_out(last), .next_out(nx));
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // answered fetches
    always @(posedge clk) begin
        if (ack === 1'h1) acks <= acks + 1;
    end
    // xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // byte-lane merge of a write into a register image
    function automatic logic [31:0] mrg(input logic [31:0] o, n, input logic [3:0] m);
        for (int i = 0; i < 4; i++) if (m[i]) o[8*i+:8] = n[8*i+:8];
        return o;
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
        input logic [3:0] m);
        int n;
        @(posedge clk);
        {psel, pwr, paddr, pwdata, pstrb} <= {1'h1, w, a, v, m};
        @(posedge clk);
        pen <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        er = pslverr;
        {psel, pen} <= 2'h0;
        if (n >= 20) begin
            fails++;
            complete_run;
        end
    endtask
    // clear, arm the memory model, start with control c, count answers
    task automatic walk(input logic [2:0] c, input logic o, l);
        apb(1'h1, `DESC_CTRL_OFFSET, 32'h0, 4'hf);
        repeat (8) @(posedge clk);
        {ow, ls, dly} <= {o, l, 2'(rnd())};
        apb(1'h1, `DESC_CTRL_OFFSET, {29'h0, c}, 4'h1);
        a0 = acks;
        repeat (60) begin
            @(posedge clk);
            if (ack === 1'h1) ls <= 1'h1;
        end
        dlt = acks - a0;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'h0;
        apb(1'h0, `DESC_CTRL_OFFSET, 32'h0, 4'h0);
        chk("ctrl reset", rd, 32'h0);
        apb(1'h1, `DESC_POINTER_OFFSET, rnd(), 4'hf);
        apb(1'h0, `DESC_POINTER_OFFSET, 32'h0, 4'h0);
        chk("pointer reset", rd, 32'h0);
        chk("tap reset", t_ddr_clk, 32'h1);
        apb(1'h0, 12'h03c, 32'h0, 4'h0);
        chk("unmapped error", er, 32'h1);
        $display("reset test done");
        tap = 32'h0;
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : rnd();
            s = (i < 2) ? 4'hf : 4'(rnd());
            apb(1'h1, `TAP_CTRL_OFFSET, d, s);
            tap = mrg(tap, d, s) & `TAP_CTRL_MASK;
            apb(1'h0, `TAP_CTRL_OFFSET, 32'h0, 4'h0);
            chk("taps", rd, tap);
            chk("ddr clock", t_ddr_clk, tap[29:24] + 1);
            chk("sdr data", t_sdr_dat, tap[23:20] + 1);
            chk("ddr out", t_ddr_out, tap[19:16] + 1);
            chk("sdr clock", t_sdr_clk, tap[13:8] + 1);
            chk("data out", t_dat_out, tap[7:4] + 1);
            chk("clock out", t_clk_out, tap[3:0] + 1);
        end
        $display("tap test done");
        // reset in mid-run with the taps still programmed
        srst <= 1'h1;
        repeat (3) @(posedge clk);
        srst <= 1'h0;
        apb(1'h0, `TAP_CTRL_OFFSET, 32'h0, 4'h0);
        chk("tap after reset", rd, 32'h0);
        chk("ddr clock reset", t_ddr_clk, 32'h1);
        chk("clock out reset", t_clk_out, 32'h1);
        $display("mid reset test done");
        ctl = 3'h0;
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            s = 4'(rnd());
            apb(1'h1, `DESC_CTRL_OFFSET, d, s);
            if (s[0]) ctl = d[2:0];
            apb(1'h0, `DESC_CTRL_OFFSET, 32'h0, 4'h0);
            chk("ctrl", rd, {29'h0, ctl});
            chk("dma level", dma, ctl[0]);
            chk("poll level", poll, ctl[1]);
        end
        $display("control test done");
        b = rnd();
        apb(1'h1, `DESC_BASE_OFFSET, b, 4'hf);
        walk(3'h7, 1'h1, 1'h1);
        chk("one fetch", dlt, 32'h1);
        chk("halted", busy, 32'h0);
        apb(1'h1, `DESC_POINTER_OFFSET, ~b, 4'hf);
        apb(1'h0, `DESC_POINTER_OFFSET, 32'h0, 4'h0);
        chk("pointer", rd, b);
        walk(3'h7, 1'h1, 1'h0);
        apb(1'h0, `DESC_POINTER_OFFSET, 32'h0, 4'h0);
        chk("chain pointer", rd, b + 32'h0000_0010);
        walk(3'h7, 1'h0, 1'h0);
        chk("polled", dlt > 2, 32'h1);
        walk(3'h5, 1'h0, 1'h0);
        chk("no poll", dlt, 32'h1);
        walk(3'h4, 1'h1, 1'h1);
        chk("dma off", dlt, 32'h0);
        walk(3'h3, 1'h1, 1'h1);
        chk("start off", dlt, 32'h0);
        chk("idle when off", busy, 32'h0);
        $display("walker test done");
        complete_run;
    end
endmodule // quad_flash_desc_ctrl_taps_tb_top
`default_nettype wire
